// [rtl/clk_src_pkg.sv]
// shared constants, types and decode helpers for clock source selection
package clk_src_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] HF_CTRL_ADDR = 8'h00;
	localparam logic [7:0] LF_CTRL_ADDR = 8'h01;

	// hf_clock_control_reg fields
	localparam int HF_KEEP_RET_BIT = 7;
	localparam int HF_EXT_DIG_BIT = 6;
	localparam int HF_START_LSB = 4;
	localparam int HF_SRC_BIT = 3;
	localparam logic [7:0] HF_CTRL_RESET = 8'h00;

	// lf_clock_control_reg fields
	localparam int LF_READY_BIT = 6;
	localparam int LF_SEL_LSB = 0;
	localparam logic [7:0] LF_CTRL_RESET = 8'h07;

	// ==========================================================
	// oscillator start field (bits 5:4)
	localparam logic [1:0] START_BOTH = 2'h0;
	localparam logic [1:0] START_RC_ONLY = 2'h1;
	localparam logic [1:0] START_XTAL_ONLY = 2'h2;

	// low-frequency source select field
	localparam logic [2:0] LF_SEL_XTAL = 3'h0;
	localparam logic [2:0] LF_SEL_RC = 3'h1;
	localparam logic [2:0] LF_SEL_SYNTH = 3'h2;
	localparam logic [2:0] LF_SEL_EXT_ANA = 3'h3;
	localparam logic [2:0] LF_SEL_EXT_DIG = 3'h4;

	// system power modes
	localparam logic [2:0] MODE_DEEP_SLEEP = 3'h0;
	localparam logic [2:0] MODE_MEM_RET_TOFF = 3'h1;
	localparam logic [2:0] MODE_MEM_RET_TON = 3'h2;
	localparam logic [2:0] MODE_REG_RET = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h4;
	localparam logic [2:0] MODE_ACTIVE = 3'h5;

	// ==========================================================
	// high-frequency controller states
	typedef enum logic [2:0] {
		HF_OFF,
		HF_RC_WAIT,
		HF_XTAL_WAIT,
		HF_XTAL,
		HF_RC_ONLY,
		HF_EXT
	} hf_state_t;

	// ==========================================================
	// modes in which the main crystal normally runs
	function automatic logic mode_is_awake(input logic [2:0] mode);
		return (mode == MODE_ACTIVE) || (mode == MODE_STANDBY);
	endfunction

	// modes in which the low-frequency domain is powered at all
	function automatic logic mode_has_lf(input logic [2:0] mode);
		return (mode != MODE_DEEP_SLEEP) && (mode != MODE_MEM_RET_TOFF);
	endfunction

endpackage

// [rtl/clock_source_select.sv]
// clock source selection: high-frequency handover and low-frequency select
// Notes on behaviour
// - default start RC and crystal together
// - RC until crystal stable, then switch over
// - bit 3 shows current high-speed source
// - bits 5:4 choose which oscillators start
// - bit 6 selects digital external clock
// - LF crystal off in deepest modes
// - select 000 enables LF crystal
// - crystal enable claims the two pins
// - bit 6 reports LF source ready
// - select 001 enables LF RC
// - RC select leaves pins free
// - select 010 derives LF from crystal
// - derived clock only while crystal runs
// - 100 digital, 011 analog external
// - bit 7 keeps crystal in register retention
`timescale 1ns/1ps
module clock_source_select
	import clk_src_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic hf_clk_req_i,
	input wire logic [2:0] sys_mode_i,
	input wire logic main_xtal_stable_i,
	input wire logic lf_xtal_ready_i,
	input wire logic lf_rc_ready_i,
	output logic fast_rc_osc_en_o,
	output logic main_xtal_osc_en_o,
	output logic hf_src_xtal_o,
	output logic hf_ext_digital_o,
	output logic lf_xtal_osc_en_o,
	output logic lf_rc_osc_en_o,
	output logic lf_synth_en_o,
	output logic lf_pin_b_ext_digital_o,
	output logic lf_pin_b_ext_analog_o,
	output logic lf_xtal_pin_a_xtal_o,
	output logic lf_xtal_pin_b_xtal_o,
	output logic lf_clk_ready_o
);

	// ==========================================================
	// reset release
	// assertion is immediate, release waits two edges to avoid metastability
	logic rst_meta_r;
	logic rst_sync_r;
	logic rstn_s;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	assign rstn_s = rst_sync_r;

	// ==========================================================
	// state
	typedef struct packed {
		hf_state_t st;
		logic keep_ret;
		logic ext_dig;
		logic [1:0] start_sel;
		logic [2:0] lf_sel;
		logic [7:0] rdata;
		logic fast_rc_en;
		logic xtal_en;
		logic src_xtal;
	} top_state_t;

	top_state_t s_r;
	top_state_t s_nxt;

	logic hf_need;
	logic keep_in_ret;
	logic hf_xtal_up;

	lf_ctrl_if lf_bus ();

	// ==========================================================
	// readback helpers
	function automatic logic [7:0] hf_readback(input top_state_t s);
		logic [7:0] v;
		v = 8'h00;
		v[HF_KEEP_RET_BIT] = s.keep_ret;
		v[HF_EXT_DIG_BIT] = s.ext_dig;
		v[HF_START_LSB +: 2] = s.start_sel;
		v[HF_SRC_BIT] = s.src_xtal;
		return v;
	endfunction

	function automatic logic [7:0] lf_readback(input logic [2:0] sel, input logic rdy);
		logic [7:0] v;
		v = 8'h00;
		v[LF_SEL_LSB +: 3] = sel;
		v[LF_READY_BIT] = rdy;
		return v;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		s_nxt = s_r;

		// high-speed clock wanted only while awake
		hf_need = hf_clk_req_i && mode_is_awake(sys_mode_i);
		keep_in_ret = s_r.keep_ret && (sys_mode_i == MODE_REG_RET) && !s_r.ext_dig;

		// register writes; start select takes effect at the next start
		if (wr_i && addr_i == HF_CTRL_ADDR) begin
			s_nxt.keep_ret = wdata_i[HF_KEEP_RET_BIT];
			s_nxt.ext_dig = wdata_i[HF_EXT_DIG_BIT];
			s_nxt.start_sel = wdata_i[HF_START_LSB +: 2];
		end
		if (wr_i && addr_i == LF_CTRL_ADDR) begin
			s_nxt.lf_sel = wdata_i[LF_SEL_LSB +: 3];
		end

		// register reads, data valid the cycle after the strobe only
		s_nxt.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				HF_CTRL_ADDR: begin
					s_nxt.rdata = hf_readback(s_r);
				end
				LF_CTRL_ADDR: begin
					s_nxt.rdata = lf_readback(s_r.lf_sel, lf_bus.ready);
				end
				default: begin
					s_nxt.rdata = 8'h00;
				end
			endcase
		end

		// high-frequency sequencing
		case (s_r.st)
			HF_OFF: begin
				if (hf_need && s_r.ext_dig) begin
					s_nxt.st = HF_EXT;
				end else if (hf_need) begin
					case (s_r.start_sel)
						START_BOTH: begin
							s_nxt.st = HF_RC_WAIT;
						end
						START_RC_ONLY: begin
							s_nxt.st = HF_RC_ONLY;
						end
						START_XTAL_ONLY: begin
							s_nxt.st = HF_XTAL_WAIT;
						end
						default: begin
							s_nxt.st = HF_RC_WAIT;
						end
					endcase
				end
			end
			// hand over once crystal is stable
			HF_RC_WAIT: begin
				if (!hf_need) begin
					s_nxt.st = HF_OFF;
				end else if (main_xtal_stable_i) begin
					s_nxt.st = HF_XTAL;
				end
			end
			HF_XTAL_WAIT: begin
				if (!hf_need) begin
					s_nxt.st = HF_OFF;
				end else if (main_xtal_stable_i) begin
					s_nxt.st = HF_XTAL;
				end
			end
			HF_XTAL: begin
				if (!hf_need) begin
					s_nxt.st = HF_OFF;
				end
			end
			HF_RC_ONLY: begin
				if (!hf_need) begin
					s_nxt.st = HF_OFF;
				end
			end
			HF_EXT: begin
				if (!hf_need || !s_r.ext_dig) begin
					s_nxt.st = HF_OFF;
				end
			end
			default: begin
				s_nxt.st = HF_OFF;
			end
		endcase

		s_nxt.fast_rc_en = (s_nxt.st == HF_RC_WAIT) || (s_nxt.st == HF_RC_ONLY);
		// crystal awake or held in retention
		s_nxt.xtal_en = (s_nxt.st == HF_RC_WAIT) || (s_nxt.st == HF_XTAL_WAIT)
			|| (s_nxt.st == HF_XTAL) || keep_in_ret;
		// zero only while RC supplies the clock
		s_nxt.src_xtal = !((s_nxt.st == HF_RC_WAIT) || (s_nxt.st == HF_RC_ONLY));
	end

	always_ff @(posedge mclk_i or negedge rstn_s) begin
		if (!rstn_s) begin
			s_r.st <= HF_OFF;
			s_r.keep_ret <= HF_CTRL_RESET[HF_KEEP_RET_BIT];
			s_r.ext_dig <= HF_CTRL_RESET[HF_EXT_DIG_BIT];
			s_r.start_sel <= HF_CTRL_RESET[HF_START_LSB +: 2];
			s_r.lf_sel <= LF_CTRL_RESET[LF_SEL_LSB +: 3];
			s_r.rdata <= 8'h00;
			s_r.fast_rc_en <= 1'b0;
			s_r.xtal_en <= 1'b0;
			s_r.src_xtal <= 1'b1;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// low-frequency side
	// crystal counts as up only once stable, so the derived clock never glitches
	assign hf_xtal_up = s_r.xtal_en && main_xtal_stable_i;

	assign lf_bus.sel = s_r.lf_sel;
	assign lf_bus.mode = sys_mode_i;
	assign lf_bus.hf_xtal_up = hf_xtal_up;
	assign lf_bus.xtal_ready = lf_xtal_ready_i;
	assign lf_bus.rc_ready = lf_rc_ready_i;

	lf_source_ctrl u_lf (
		.mclk_i (mclk_i),
		.rstn_i (rstn_s),
		.ce_i (ce_i),
		.lf (lf_bus.src)
	);

	// ==========================================================
	// outputs
	assign rdata_o = s_r.rdata;
	assign fast_rc_osc_en_o = s_r.fast_rc_en;
	assign main_xtal_osc_en_o = s_r.xtal_en;
	assign hf_src_xtal_o = s_r.src_xtal;
	assign hf_ext_digital_o = (s_r.st == HF_EXT);
	assign lf_xtal_osc_en_o = lf_bus.xtal_en;
	assign lf_rc_osc_en_o = lf_bus.rc_en;
	assign lf_synth_en_o = lf_bus.synth_en;
	assign lf_pin_b_ext_digital_o = lf_bus.ext_dig;
	assign lf_pin_b_ext_analog_o = lf_bus.ext_ana;
	assign lf_xtal_pin_a_xtal_o = lf_bus.pins_xtal;
	assign lf_xtal_pin_b_xtal_o = lf_bus.pins_xtal;
	assign lf_clk_ready_o = lf_bus.ready;

endmodule // clock_source_select

// [rtl/lf_ctrl_if.sv]
// bundle between the register side and the low-frequency source controller
`timescale 1ns/1ps
interface lf_ctrl_if;
	logic [2:0] sel;
	logic [2:0] mode;
	logic hf_xtal_up;
	logic xtal_ready;
	logic rc_ready;
	logic xtal_en;
	logic rc_en;
	logic synth_en;
	logic ext_dig;
	logic ext_ana;
	logic pins_xtal;
	logic ready;

	modport ctrl (
		output sel, mode, hf_xtal_up, xtal_ready, rc_ready,
		input xtal_en, rc_en, synth_en, ext_dig, ext_ana, pins_xtal, ready
	);
	modport src (
		input sel, mode, hf_xtal_up, xtal_ready, rc_ready,
		output xtal_en, rc_en, synth_en, ext_dig, ext_ana, pins_xtal, ready
	);
endinterface

// [rtl/lf_source_ctrl.sv]
// low-frequency clock source decode, enables and ready tracking
`timescale 1ns/1ps
module lf_source_ctrl
	import clk_src_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	lf_ctrl_if.src lf
);

	typedef struct packed {
		logic xtal_en;
		logic rc_en;
		logic synth_en;
		logic ext_dig;
		logic ext_ana;
		logic pins_xtal;
		logic ready;
	} lf_state_t;

	lf_state_t s_r;
	lf_state_t s_nxt;
	logic powered;
	logic synth_ok;

	// ==========================================================
	// next state
	always_comb begin
		s_nxt = '0;
		powered = mode_has_lf(lf.mode);
		synth_ok = (lf.mode == MODE_REG_RET || mode_is_awake(lf.mode)) && lf.hf_xtal_up;
		case (lf.sel)
			LF_SEL_XTAL: begin
				s_nxt.xtal_en = powered;
				s_nxt.pins_xtal = 1'b1;
				s_nxt.ready = powered && lf.xtal_ready;
			end
			LF_SEL_RC: begin
				s_nxt.rc_en = powered;
				s_nxt.ready = powered && lf.rc_ready;
			end
			LF_SEL_SYNTH: begin
				s_nxt.synth_en = synth_ok;
				s_nxt.ready = synth_ok;
			end
			LF_SEL_EXT_ANA: begin
				s_nxt.ext_ana = powered;
				s_nxt.ready = powered;
			end
			LF_SEL_EXT_DIG: begin
				s_nxt.ext_dig = powered;
				s_nxt.ready = powered;
			end
			default: begin
				s_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign lf.xtal_en = s_r.xtal_en;
	assign lf.rc_en = s_r.rc_en;
	assign lf.synth_en = s_r.synth_en;
	assign lf.ext_dig = s_r.ext_dig;
	assign lf.ext_ana = s_r.ext_ana;
	assign lf.pins_xtal = s_r.pins_xtal;
	assign lf.ready = s_r.ready;

endmodule // lf_source_ctrl

// [verif/clock_source_select_checker.sv]
// port assertions for the clock source selector
`timescale 1ns/1ps
module clock_source_select_checker
	import clk_src_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic hf_clk_req_i,
	input wire logic [2:0] sys_mode_i,
	input wire logic main_xtal_stable_i,
	input wire logic fast_rc_osc_en_o,
	input wire logic main_xtal_osc_en_o,
	input wire logic hf_src_xtal_o,
	input wire logic hf_ext_digital_o,
	input wire logic lf_xtal_osc_en_o,
	input wire logic lf_rc_osc_en_o,
	input wire logic lf_synth_en_o,
	input wire logic lf_pin_b_ext_digital_o,
	input wire logic lf_pin_b_ext_analog_o,
	input wire logic lf_xtal_pin_a_xtal_o,
	input wire logic lf_xtal_pin_b_xtal_o,
	input wire logic lf_clk_ready_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// ==========================================================
	// high-frequency side
	a_both_rc_src: assert property (
		fast_rc_osc_en_o && main_xtal_osc_en_o |-> !hf_src_xtal_o) else $error("rc not source");
	a_xtal_handover: assert property (
		ce_i && hf_clk_req_i && sys_mode_i >= MODE_STANDBY && fast_rc_osc_en_o
		&& main_xtal_osc_en_o && main_xtal_stable_i |-> ##[1:2] (!fast_rc_osc_en_o
		&& hf_src_xtal_o)) else $error("no handover to crystal");
	a_src_flag: assert property (
		!hf_src_xtal_o |-> fast_rc_osc_en_o && !hf_ext_digital_o) else $error("bad source flag");
	a_hf_ext_off: assert property (
		hf_ext_digital_o |-> !fast_rc_osc_en_o && !main_xtal_osc_en_o && hf_src_xtal_o)
		else $error("oscillator on with external clock");
	a_hf_req_off: assert property (
		ce_i && !hf_clk_req_i && sys_mode_i != MODE_REG_RET |=> !fast_rc_osc_en_o
		&& !hf_ext_digital_o) else $error("hf source kept without request");
	// ==========================================================
	// low-frequency side
	a_lf_onehot: assert property ($onehot0({lf_xtal_osc_en_o, lf_rc_osc_en_o,
		lf_synth_en_o, lf_pin_b_ext_digital_o, lf_pin_b_ext_analog_o}))
		else $error("several lf sources");
	a_lf_deep_off: assert property (
		ce_i && sys_mode_i <= MODE_MEM_RET_TOFF |=> !lf_xtal_osc_en_o && !lf_clk_ready_o)
		else $error("lf crystal on in deep mode");
	a_lf_pins: assert property (
		lf_xtal_pin_a_xtal_o == lf_xtal_pin_b_xtal_o && (lf_rc_osc_en_o -> !lf_xtal_pin_a_xtal_o))
		else $error("lf pins claimed wrongly");
	a_synth_ready: assert property (
		lf_clk_ready_o && lf_synth_en_o |-> $past(sys_mode_i) >= MODE_REG_RET)
		else $error("synth ready without crystal mode");
	a_lf_ready_src: assert property (lf_clk_ready_o |-> lf_xtal_osc_en_o ||
		lf_rc_osc_en_o || lf_synth_en_o || lf_pin_b_ext_digital_o || lf_pin_b_ext_analog_o)
		else $error("ready with no source");
endmodule // clock_source_select_checker

// [verif/osc_partner.sv]
// oscillator stand-ins with a prompt or slow start-up
`timescale 1ns/1ps
module osc_partner (
	input wire logic mclk_i,
	input wire logic slow_i,
	input wire logic main_xtal_en_i,
	input wire logic lf_xtal_en_i,
	input wire logic lf_rc_en_i,
	output logic hf_stable_o,
	output logic lf_xtal_ready_o,
	output logic lf_rc_ready_o
);
	int c0, c1, c2, lim;
	// ==========================================================
	// start-up counters; an oscillator stops at once when disabled
	always @(posedge mclk_i) begin
		c0 <= main_xtal_en_i ? c0 + 1 : 0;
		c1 <= lf_xtal_en_i ? c1 + 1 : 0;
		c2 <= lf_rc_en_i ? c2 + 1 : 0;
	end
	assign lim = slow_i ? 40 : 6;
	assign hf_stable_o = main_xtal_en_i && c0 > lim;
	assign lf_xtal_ready_o = lf_xtal_en_i && c1 > lim;
	assign lf_rc_ready_o = lf_rc_en_i && c2 > lim;
endmodule // osc_partner

// [verif/tb_top.sv]
// self-checking bench for the clock source selector
`timescale 1ns/1ps
module tb_top;
	import clk_src_pkg::*;
	logic mclk_i = 0, rstn_i = 0, ce_i = 1, wr_i = 0, rd_i = 0, hf_clk_req_i = 0, slow = 1;
	logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
	logic [2:0] sys_mode_i = MODE_ACTIVE;
	logic main_xtal_stable_i, lf_xtal_ready_i, lf_rc_ready_i, lf_clk_ready_o;
	logic fast_rc_osc_en_o, main_xtal_osc_en_o, hf_src_xtal_o, hf_ext_digital_o;
	logic lf_xtal_osc_en_o, lf_rc_osc_en_o, lf_synth_en_o, lf_pin_b_ext_digital_o;
	logic lf_pin_b_ext_analog_o, lf_xtal_pin_a_xtal_o, lf_xtal_pin_b_xtal_o;
	int fails = 0, num_checks = 0, hf_m, lf_m;
	wire [6:0] lf_v = {lf_xtal_osc_en_o, lf_rc_osc_en_o, lf_synth_en_o, lf_pin_b_ext_digital_o,
		lf_pin_b_ext_analog_o, lf_xtal_pin_a_xtal_o, lf_xtal_pin_b_xtal_o};
	// crystal only uses start 10 with bit 6 clear
	localparam logic [7:0] HF_CODE [4] = '{8'h10, 8'h20, 8'h40, 8'h30};
	localparam logic [3:0] HF_EXP [4] = '{4'h8, 4'h5, 4'h3, 4'hc};
	localparam logic [6:0] LFE [8] = '{7'h43, 7'h20, 7'h10, 7'h04, 7'h08, 7'h00, 7'h00, 7'h00};

	clock_source_select i_clock_source_select (.mclk_i, .rstn_i, .ce_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .hf_clk_req_i, .sys_mode_i, .main_xtal_stable_i,
		.lf_xtal_ready_i, .lf_rc_ready_i, .fast_rc_osc_en_o, .main_xtal_osc_en_o,
		.hf_src_xtal_o, .hf_ext_digital_o, .lf_xtal_osc_en_o, .lf_rc_osc_en_o, .lf_synth_en_o,
		.lf_pin_b_ext_digital_o, .lf_pin_b_ext_analog_o, .lf_xtal_pin_a_xtal_o,
		.lf_xtal_pin_b_xtal_o, .lf_clk_ready_o);
	osc_partner i_osc_partner (.mclk_i, .slow_i(slow), .main_xtal_en_i(main_xtal_osc_en_o),
		.lf_xtal_en_i(lf_xtal_osc_en_o), .lf_rc_en_i(lf_rc_osc_en_o),
		.hf_stable_o(main_xtal_stable_i), .lf_xtal_ready_o(lf_xtal_ready_i),
		.lf_rc_ready_o(lf_rc_ready_i));

	initial begin
		forever #50 mclk_i = ~mclk_i;
	end
	// ==========================================================
	// bus and check helpers
	task automatic chk(input string n, input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp, input string n);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(negedge mclk_i);
		chk(n, rdata_o, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// w 0: crystal took over, w 1: lf clock ready
	task automatic await(input int w);
		int i;
		for (i = 0; i < 300; i++) begin
			@(negedge mclk_i);
			if (w == 0 ? main_xtal_osc_en_o === 1'b1 && fast_rc_osc_en_o === 1'b0
				: lf_clk_ready_o === 1'b1) break;
		end
		if (i == 300) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk_i);
		fails++;
		report_and_stop();
	end
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(38));
		repeat (12) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		rd(HF_CTRL_ADDR, 8'h08, "hf reset");
		rd(LF_CTRL_ADDR, 8'h07, "lf reset");
		rd(8'h05, 8'h00, "unmapped");
		$display("reset test done");
		@(posedge mclk_i) hf_clk_req_i <= 1'b1;
		tick(2);
		chk("hf start", {fast_rc_osc_en_o, main_xtal_osc_en_o, hf_src_xtal_o}, 3'b110);
		rd(HF_CTRL_ADDR, 8'h00, "hf on rc");
		await(0);
		chk("hf handover", {fast_rc_osc_en_o, hf_src_xtal_o}, 2'b01);
		rd(HF_CTRL_ADDR, 8'h08, "hf on crystal");
		@(posedge mclk_i) hf_clk_req_i <= 1'b0;
		tick(2);
		$display("handover test done");
		// bit 6 set only here, with no radio in use
		for (int k = 0; k < 4; k++) begin
			hf_m = HF_CODE[k] | ($urandom & 15);
			wr(HF_CTRL_ADDR, 8'(hf_m));
			rd(HF_CTRL_ADDR, 8'(hf_m & 'hf0 | 'h08), "hf config");
			@(posedge mclk_i) hf_clk_req_i <= 1'b1;
			// standby must start the oscillators just as active does
			sys_mode_i <= k[0] ? MODE_STANDBY : MODE_ACTIVE;
			tick(2);
			chk("hf mode", {fast_rc_osc_en_o, main_xtal_osc_en_o, hf_ext_digital_o,
				hf_src_xtal_o}, HF_EXP[k]);
			@(posedge mclk_i) hf_clk_req_i <= 1'b0;
			tick(2);
		end
		$display("start mode test done");
		for (int k = 0; k < 2; k++) begin
			wr(HF_CTRL_ADDR, k ? 8'h00 : 8'h80);
			@(posedge mclk_i) hf_clk_req_i <= 1'b1;
			await(0);
			@(posedge mclk_i) sys_mode_i <= MODE_REG_RET;
			tick(3);
			chk("xtal in retention", main_xtal_osc_en_o, k ? 1'b0 : 1'b1);
			@(posedge mclk_i) sys_mode_i <= MODE_ACTIVE;
		end
		$display("retention test done");
		slow <= 1'b0;
		await(0);
		for (int s = 0; s < 8; s++) begin
			lf_m = s;
			wr(LF_CTRL_ADDR, 8'($urandom) & 8'hf8 | 8'(lf_m));
			tick(2);
			if (s < 5) await(1);
			chk("lf outputs", lf_v, LFE[s]);
			rd(LF_CTRL_ADDR, 8'((s < 5 ? 'h40 : 0) | lf_m), "lf status");
		end
		wr(LF_CTRL_ADDR, 8'h02);
		@(posedge mclk_i) sys_mode_i <= MODE_MEM_RET_TON;
		tick(3);
		chk("synth in mem ret", lf_clk_ready_o, 1'b0);
		wr(LF_CTRL_ADDR, 8'h00);
		@(posedge mclk_i) sys_mode_i <= MODE_MEM_RET_TOFF;
		tick(3);
		chk("lf xtal timer off", lf_xtal_osc_en_o, 1'b0);
		@(posedge mclk_i) sys_mode_i <= MODE_DEEP_SLEEP;
		tick(3);
		chk("lf xtal deep sleep", {lf_xtal_osc_en_o, lf_clk_ready_o}, 2'b00);
		@(posedge mclk_i) sys_mode_i <= MODE_MEM_RET_TON;
		await(1);
		@(posedge mclk_i) ce_i <= 1'b0;
		wr(LF_CTRL_ADDR, 8'h01);
		@(posedge mclk_i) ce_i <= 1'b1;
		rd(LF_CTRL_ADDR, 8'h40, "write while frozen");
		$display("lf select test done");
		report_and_stop();
	end
endmodule // tb_top

bind clock_source_select clock_source_select_checker i_clock_source_select_checker (.mclk_i,
	.rstn_i, .ce_i, .hf_clk_req_i, .sys_mode_i, .main_xtal_stable_i, .fast_rc_osc_en_o,
	.main_xtal_osc_en_o, .hf_src_xtal_o, .hf_ext_digital_o, .lf_xtal_osc_en_o, .lf_rc_osc_en_o,
	.lf_synth_en_o, .lf_pin_b_ext_digital_o, .lf_pin_b_ext_analog_o, .lf_xtal_pin_a_xtal_o,
	.lf_xtal_pin_b_xtal_o, .lf_clk_ready_o);
